// file: hdl/dfc_pkg.sv
// Shared constants, types and register map of the decimating filter chain
package dfc_pkg;

	// ************************************************************
	// Register map (byte addresses on the plain register port)
	// ************************************************************
	localparam logic [3:0]  DFC_REG_CONFIG = 4'h0;   // Filter configuration
	localparam logic [3:0]  DFC_REG_OFFSET = 4'h4;   // High-pass accumulator seed
	localparam logic [3:0]  DFC_REG_HPCOEF = 4'h8;   // High-pass coefficient a x 2^16
	localparam logic [3:0]  DFC_REG_STATUS = 4'hC;   // Read-only state

	// ************************************************************
	// Configuration field positions and reset values
	// ************************************************************
	localparam int          DFC_CFG_PATH_LSB  = 0;   // filter_path_field [1:0]
	localparam int          DFC_CFG_PHASE_BIT = 2;   // 1 = minimum phase
	localparam int          DFC_CFG_RATE_LSB  = 3;   // decimation_rate_select [5:3]
	localparam int          DFC_CFG_LOWP_BIT  = 6;   // Low-power modulator rate
	localparam logic [6:0]  DFC_CFG_RESET     = 7'h1A;
	localparam logic [31:0] DFC_OFFSET_RESET  = 32'h0000_0000;
	localparam logic [15:0] DFC_HPCOEF_RESET  = 16'h0100;

	// ************************************************************
	// Timing and decimation constants
	// ************************************************************
	localparam int          DFC_CLK_HZ        = 25_000_000;
	localparam logic [3:0]  DFC_MOD_DIV       = 4'h4;   // modulator_rate = clock / 4
	localparam logic [3:0]  DFC_MOD_DIV_LOWP  = 4'h8;   // clock / 8
	localparam int          DFC_SINC_LOG_BASE = 3;      // N = 2^(rate + 3), rate 3 gives 64
	localparam int          DFC_SINC_ORDER    = 5;
	localparam int          DFC_FIR_STAGES    = 4;
	localparam logic [5:0]  DFC_FIR_DECIM     = 6'h20;  // Total FIR decimation 32
	localparam int          DFC_FIR_DECIM_LOG = 5;
	localparam logic [5:0]  DFC_SETTLE_CONV   = 6'h3E;  // 62 conversions
	localparam int          DFC_FIFO_DEPTH    = 16;
	localparam logic signed [31:0] DFC_CLIP_MAX = 32'sh007F_FFFF;
	localparam logic signed [31:0] DFC_CLIP_MIN = -32'sh0080_0000;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		DFC_PATH_SINC = 2'b00,
		DFC_PATH_FIRX = 2'b01,
		DFC_PATH_FIR  = 2'b10,
		DFC_PATH_HPF  = 2'b11
	} dfc_path_type;

	typedef struct packed {
		logic              sincPath;   // Word is raw sinc data
		logic signed [31:0] value;     // Result word
	} dfc_word_type;

endpackage

// file: hdl/dfc_filter_chain.sv
// Decimating sinc / FIR / high-pass filter chain with output FIFO
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// Synchronous FIFO with valid/ready on both sides
// ************************************************************
module dfc_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst,
	// Fill side
	input  wire logic [WIDTH-1:0]         inData,
	input  wire logic                     inValid,
	output logic                          inReady,
	// Drain side
	output logic [WIDTH-1:0]              outData,
	output logic                          outValid,
	input  wire logic                     outReady,
	// Fill level
	output logic [$clog2(DEPTH):0]        level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [0:DEPTH-1];   // Word storage
	logic [AW:0]      wrPtr_reg;           // Write pointer with wrap bit
	logic [AW:0]      rdPtr_reg;           // Read pointer with wrap bit
	logic             doPush;              // Word accepted
	logic             doPop;               // Word delivered

	assign level    = wrPtr_reg - rdPtr_reg;
	assign inReady  = (level != (AW+1)'(DEPTH));
	assign outValid = (level != '0);
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;
	assign outData  = store[rdPtr_reg[AW-1:0]];

	// Storage write, no reset needed on data
	always_ff @(posedge clock) begin
		if (doPush) begin
			store[wrPtr_reg[AW-1:0]] <= inData;
		end
	end

	// Pointer update
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_reg + (AW+1)'(doPush);
			rdPtr_reg <= rdPtr_reg + (AW+1)'(doPop);
		end
	end
endmodule

// ************************************************************
// Filter chain top
// ************************************************************
module dfc_filter_chain (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst,
	// Register port
	input  wire logic [3:0]           regAddr,
	input  wire logic [31:0]          regWData,
	input  wire logic                 regWrite,
	input  wire logic                 regRead,
	output logic [31:0]               regRData,
	// Modulator samples
	input  wire logic signed [3:0]    modSample,
	output logic                      modTake,
	// Result stream
	output dfc_pkg::dfc_word_type     outWord,
	output logic                      outValid,
	input  wire logic                 outReady
);
	import dfc_pkg::*;

	// ************************************************************
	// Registers
	// ************************************************************
	logic [6:0]         cfg_reg;          // Configuration
	logic [31:0]        offset_reg;       // High-pass seed
	logic [15:0]        coef_reg;         // High-pass coefficient
	logic [31:0]        rdata_reg;        // Read answer
	logic [31:0]        readMux;          // Selected read value
	logic               restart;          // Chain restart pulse
	dfc_path_type       path;             // Selected path
	logic               minPhase;         // Minimum phase selected
	logic [2:0]         rateSel;          // decimation_rate_select
	logic               hpEnabled;        // High-pass active
	logic               fifoInReady;      // FIFO has room
	logic [4:0]         fifoLevel;        // FIFO fill level
	logic [5:0]         settle_reg;       // FIR conversions since restart

	assign path      = dfc_path_type'(cfg_reg[DFC_CFG_PATH_LSB +: 2]);
	assign minPhase  = cfg_reg[DFC_CFG_PHASE_BIT];
	assign rateSel   = cfg_reg[DFC_CFG_RATE_LSB +: 3];
	assign hpEnabled = (path == DFC_PATH_HPF);
	// Restart when rate, phase or path actually changes
	assign restart   = regWrite && (regAddr == DFC_REG_CONFIG)
		&& (regWData[5:0] != cfg_reg[5:0]);

	// Register writes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_reg    <= DFC_CFG_RESET;
			offset_reg <= DFC_OFFSET_RESET;
			coef_reg   <= DFC_HPCOEF_RESET;
		end else if (regWrite) begin
			if (regAddr == DFC_REG_CONFIG) begin
				cfg_reg <= regWData[6:0];
			end else if (regAddr == DFC_REG_OFFSET) begin
				offset_reg <= regWData;
			end else if (regAddr == DFC_REG_HPCOEF) begin
				coef_reg <= regWData[15:0];
			end
		end
	end

	// Read decode; unmapped addresses read zero
	always_comb begin
		if (regAddr == DFC_REG_CONFIG) begin
			readMux = {25'h0, cfg_reg};
		end else if (regAddr == DFC_REG_OFFSET) begin
			readMux = offset_reg;
		end else if (regAddr == DFC_REG_HPCOEF) begin
			readMux = {16'h0, coef_reg};
		end else if (regAddr == DFC_REG_STATUS) begin
			readMux = {23'h0, fifoLevel, (settle_reg == DFC_SETTLE_CONV), fifoInReady, 1'b0, hpEnabled};
		end else begin
			readMux = 32'h0000_0000;
		end
	end

	// Read data stand one cycle after the strobe only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= regRead ? readMux : 32'h0000_0000;
		end
	end
	assign regRData = rdata_reg;

	// ************************************************************
	// Modulator rate divider and dither
	// ************************************************************
	logic [2:0]         div_reg;          // Clock divider
	logic [3:0]         divLimit;         // Divide ratio
	logic               divTick;          // Modulator-rate enable
	logic               modTick;          // Tick not stalled by FIFO
	logic [14:0]        dith_reg;         // Dither period counter
	logic [14:0]        dithHalf;         // Half dither period
	logic               dithSign_reg;     // Dither square wave

	assign divLimit = cfg_reg[DFC_CFG_LOWP_BIT] ? DFC_MOD_DIV_LOWP : DFC_MOD_DIV;
	assign divTick  = ({1'b0, div_reg} == divLimit - 4'h1);
	// Back-pressure: a full FIFO freezes the whole chain
	assign modTick  = divTick && fifoInReady;
	assign modTake  = modTick;
	// Period = N * 32 modulator samples, so half is N * 16
	// Shift amount kept four bits wide so rate 1 and up do not wrap
	assign dithHalf = 15'(15'h1 << ({1'b0, rateSel} + 4'h7));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_reg      <= 3'h0;
			dith_reg     <= 15'h0000;
			dithSign_reg <= 1'b0;
		end else begin
			div_reg <= divTick ? 3'h0 : div_reg + 3'h1;
			if (restart) begin
				dith_reg     <= 15'h0000;
				dithSign_reg <= 1'b0;
			end else if (modTick) begin
				// Toggle twice per full dither period
				if (dith_reg == dithHalf - 15'h1) begin
					dith_reg     <= 15'h0000;
					dithSign_reg <= ~dithSign_reg;
				end else begin
					dith_reg <= dith_reg + 15'h1;
				end
			end
		end
	end

	// ************************************************************
	// Resampler: pass-through register stage feeding the sinc
	// ************************************************************
	logic signed [4:0]  src_reg;          // Resampled, dithered sample
	logic               srcValid_reg;     // Sample ready for sinc

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			src_reg      <= 5'sh00;
			srcValid_reg <= 1'b0;
		end else begin
			// Dither adds plus or minus one step to each sample
			src_reg      <= 5'(modSample) + (dithSign_reg ? 5'h1F : 5'h01);
			srcValid_reg <= modTick && !restart;
		end
	end

	// ************************************************************
	// Fifth-order sinc decimator (integrators, then combs)
	// ************************************************************
	logic signed [55:0] integ_reg [0:DFC_SINC_ORDER-1];   // Integrators
	logic signed [55:0] combDly_reg [0:DFC_SINC_ORDER-1]; // Comb delays
	logic signed [55:0] combOut [0:DFC_SINC_ORDER];       // Comb chain
	logic [9:0]         sincCnt_reg;      // Decimation counter
	logic [9:0]         sincLast;         // N - 1
	logic               sincDump;         // Decimation instant
	logic signed [31:0] sinc_reg;         // Normalised sinc word
	logic               sincValid_reg;    // New sinc word
	logic [5:0]         normShift;        // Left shift for unity gain
	logic signed [55:0] sincNorm;         // Shifted comb output

	assign sincLast  = 10'((11'h1 << ({1'b0, rateSel} + 4'h3)) - 11'h1);
	assign sincDump  = srcValid_reg && (sincCnt_reg == sincLast);
	assign combOut[0] = integ_reg[DFC_SINC_ORDER-1];
	// Gain is N^5; shift so the full scale lands on bit 53
	assign normShift = 6'(6'd35 - 6'd5 * {3'h0, rateSel});
	assign sincNorm  = combOut[DFC_SINC_ORDER] <<< normShift;

	genvar gi;
	generate
		for (gi = 0; gi < DFC_SINC_ORDER; gi++) begin : gSinc
			// Comb section difference
			assign combOut[gi+1] = combOut[gi] - combDly_reg[gi];
			// Integrator at input rate, comb at decimated rate
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					integ_reg[gi]   <= '0;
					combDly_reg[gi] <= '0;
				end else if (restart) begin
					integ_reg[gi]   <= '0;
					combDly_reg[gi] <= '0;
				end else begin
					if (srcValid_reg) begin
						integ_reg[gi] <= integ_reg[gi] + ((gi == 0) ? 56'(src_reg) : integ_reg[(gi == 0) ? 0 : gi - 1]);
					end
					if (sincDump) begin
						combDly_reg[gi] <= combOut[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sincCnt_reg   <= 10'h000;
			sinc_reg      <= 32'sh0000_0000;
			sincValid_reg <= 1'b0;
		end else if (restart) begin
			sincCnt_reg   <= 10'h000;
			sincValid_reg <= 1'b0;
		end else begin
			sincValid_reg <= sincDump;
			if (srcValid_reg) begin
				sincCnt_reg <= sincDump ? 10'h000 : sincCnt_reg + 10'h001;
			end
			if (sincDump) begin
				sinc_reg <= sincNorm[53:22];
			end
		end
	end

	// ************************************************************
	// Four-stage FIR: decimate by 2, 2, 4, 2
	// ************************************************************
	logic signed [31:0] firData [0:DFC_FIR_STAGES];   // Stage outputs
	logic               firValid [0:DFC_FIR_STAGES];  // Stage strobes

	assign firData[0]  = sinc_reg;
	assign firValid[0] = sincValid_reg;

	generate
		for (gi = 0; gi < DFC_FIR_STAGES; gi++) begin : gFir
			localparam int LOGD = (gi == 2) ? 2 : 1;
			logic [1:0]         cnt_reg;       // Input count in block
			logic signed [39:0] sum_reg;       // Running block sum
			logic signed [39:0] prev_reg;      // Previous block sum
			logic signed [39:0] blockSum;      // Block sum with newest input
			logic signed [39:0] twoBlock;      // Symmetric two-block sum
			logic signed [31:0] stageOut;      // Chosen response
			logic               useMin;        // Short-delay coefficient set
			logic               dump;          // Block complete
			logic signed [31:0] out_reg;
			logic               outV_reg;

			assign blockSum = sum_reg + 40'(firData[gi]);
			assign twoBlock = blockSum + prev_reg;
			assign dump     = firValid[gi] && (cnt_reg == 2'((1 << LOGD) - 1));
			// Half-bands always symmetric; stages three, four follow phase bit
			assign useMin   = (gi >= 2) && minPhase;
			assign stageOut = useMin ? 32'(blockSum >>> LOGD) : 32'(twoBlock >>> (LOGD + 1));

			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					cnt_reg  <= 2'h0;
					sum_reg  <= '0;
					prev_reg <= '0;
					out_reg  <= 32'sh0000_0000;
					outV_reg <= 1'b0;
				end else if (restart) begin
					cnt_reg  <= 2'h0;
					sum_reg  <= '0;
					prev_reg <= '0;
					outV_reg <= 1'b0;
				end else begin
					outV_reg <= dump;
					if (dump) begin
						cnt_reg  <= 2'h0;
						sum_reg  <= '0;
						prev_reg <= blockSum;
						out_reg  <= stageOut;
					end else if (firValid[gi]) begin
						cnt_reg <= cnt_reg + 2'h1;
						sum_reg <= blockSum;
					end
				end
			end
			assign firData[gi+1]  = out_reg;
			assign firValid[gi+1] = outV_reg;
		end
	endgenerate

	// ************************************************************
	// Calibration (unity here), clipping and high-pass stage
	// ************************************************************
	logic signed [31:0] clipped;          // FIR result clipped to 24 bits
	logic signed [31:0] fir_reg;          // Calibrated, clipped FIR word
	logic               firOut_reg;       // New FIR word
	logic signed [47:0] hpAcc_reg;        // High-pass dc accumulator
	logic signed [47:0] hpDiff;           // Input minus tracked dc
	logic signed [64:0] hpStep;           // Coefficient times difference
	logic               hpPrev_reg;       // High-pass enable last cycle
	logic signed [31:0] hp_reg;           // High-pass output word
	logic               hpOut_reg;        // New high-pass word

	// Calibration stage is unity gain, zero offset, then clip
	assign clipped = (firData[DFC_FIR_STAGES] > DFC_CLIP_MAX) ? DFC_CLIP_MAX
		: (firData[DFC_FIR_STAGES] < DFC_CLIP_MIN) ? DFC_CLIP_MIN
		: firData[DFC_FIR_STAGES];
	assign hpDiff  = {firData[DFC_FIR_STAGES], 16'h0000} - hpAcc_reg;
	assign hpStep  = 65'(hpDiff) * 65'(signed'({1'b0, coef_reg}));

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fir_reg    <= 32'sh0000_0000;
			firOut_reg <= 1'b0;
			hpAcc_reg  <= '0;
			hpPrev_reg <= 1'b0;
			hp_reg     <= 32'sh0000_0000;
			hpOut_reg  <= 1'b0;
		end else begin
			hpPrev_reg <= hpEnabled;
			firOut_reg <= firValid[DFC_FIR_STAGES] && !restart;
			hpOut_reg  <= firValid[DFC_FIR_STAGES] && hpEnabled && !restart;
			if (firValid[DFC_FIR_STAGES]) begin
				fir_reg <= clipped;
			end
			// Seed only on the disabled-to-enabled edge
			if (hpEnabled && !hpPrev_reg) begin
				hpAcc_reg <= {offset_reg, 16'h0000};
			end else if (firValid[DFC_FIR_STAGES] && hpEnabled) begin
				hpAcc_reg <= hpAcc_reg + 48'(hpStep >>> 16);
				hp_reg    <= (hpDiff[47:16] > DFC_CLIP_MAX) ? DFC_CLIP_MAX
					: (hpDiff[47:16] < DFC_CLIP_MIN) ? DFC_CLIP_MIN : hpDiff[47:16];
			end
		end
	end

	// ************************************************************
	// Settling counter
	// ************************************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			settle_reg <= 6'h00;
		end else if (restart) begin
			settle_reg <= 6'h00;
		end else if (firOut_reg && (settle_reg != DFC_SETTLE_CONV)) begin
			settle_reg <= settle_reg + 6'h01;
		end
	end

	// ************************************************************
	// Path selection and output FIFO
	// ************************************************************
	dfc_word_type       pushWord;         // Word offered to FIFO
	logic               pushValid;        // One-cycle push strobe
	logic               sincSel;          // Sinc path chosen

	assign sincSel   = (path == DFC_PATH_SINC);
	// Sinc words skip FIR, clipping and calibration entirely
	assign pushValid = sincSel ? (sincValid_reg && !restart)
		: (hpEnabled ? hpOut_reg : firOut_reg);
	assign pushWord.sincPath = sincSel;
	assign pushWord.value    = sincSel ? sinc_reg
		: (hpEnabled ? hp_reg : fir_reg);

	dfc_fifo #(
		.WIDTH ($bits(dfc_word_type)),
		.DEPTH (DFC_FIFO_DEPTH)
	) uFifo (
		.clock    (clock),
		.rst      (rst),
		.inData   (pushWord),
		.inValid  (pushValid),
		.inReady  (fifoInReady),
		.outData  (outWord),
		.outValid (outValid),
		.outReady (outReady),
		.level    (fifoLevel)
	);
endmodule

`default_nettype wire

// file: tb/dfc_modulator_model.sv
// Modulator stand-in that holds a set level on the sample bus
`timescale 1ns/1ns
`default_nettype none
module dfc_modulator_model
	import dfc_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Sample handshake
	input  wire logic              modTake,
	input  wire logic signed [3:0] level,
	output logic signed [3:0]      modSample,
	// Samples taken so far
	output logic [15:0]            takes
);
	// Present the level and count the samples taken
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			modSample <= 4'sh0;
			takes     <= 16'h0;
		end else begin
			modSample <= level;
			if (modTake) begin
				takes <= takes + 16'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/dfc_filter_chain_checker.sv
// Port assertions for the filter chain
`timescale 1ns/1ns
`default_nettype none
module dfc_filter_chain_checker
	import dfc_pkg::*;
(
	// Clock and reset
	input wire logic                 clock,
	input wire logic                 rst,
	// Register port
	input wire logic [3:0]           regAddr,
	input wire logic [31:0]          regWData,
	input wire logic                 regWrite,
	input wire logic                 regRead,
	input wire logic [31:0]          regRData,
	// Samples and results
	input wire logic signed [3:0]    modSample,
	input wire logic                 modTake,
	input wire dfc_pkg::dfc_word_type outWord,
	input wire logic                 outValid,
	input wire logic                 outReady
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Address decodes to one of the four registers
	wire mapped = regAddr inside {DFC_REG_CONFIG, DFC_REG_OFFSET, DFC_REG_HPCOEF, DFC_REG_STATUS};
	property p_rdIdle; !$past(regRead) |-> regRData == 32'h0; endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data not zero");
	property p_rdUnmap; regRead && !mapped |=> regRData == 32'h0; endproperty
	a_rdUnmap: assert property (p_rdUnmap) else $error("unmapped read");
	property p_rdCfg; regRead && regAddr == DFC_REG_CONFIG |=> regRData[31:7] == 25'h0; endproperty
	a_rdCfg: assert property (p_rdCfg) else $error("config upper bits");
	property p_rdCoef; regRead && regAddr == DFC_REG_HPCOEF |=> regRData[31:16] == 16'h0; endproperty
	a_rdCoef: assert property (p_rdCoef) else $error("coefficient upper bits");
	property p_rdStat; regRead && regAddr == DFC_REG_STATUS |=> regRData[31:9] == 23'h0 && !regRData[1]; endproperty
	a_rdStat: assert property (p_rdStat) else $error("status layout");
	property p_modGap; modTake |=> !modTake [*3]; endproperty
	a_modGap: assert property (p_modGap) else $error("samples too close");
	property p_modLive; !outValid |-> ##[0:9] modTake; endproperty
	a_modLive: assert property (p_modLive) else $error("sample ticks stalled");
	property p_hold; outValid && !outReady |=> outValid && $stable(outWord); endproperty
	a_hold: assert property (p_hold) else $error("head word moved");
	c_take: cover property (modTake);
	c_sinc: cover property (outValid && outReady && outWord.sincPath);
	c_fir: cover property (outValid && outReady && !outWord.sincPath);
endmodule
bind dfc_filter_chain dfc_filter_chain_checker i_dfc_filter_chain_checker (.clock(clock), .rst(rst),
	.regAddr(regAddr), .regWData(regWData), .regWrite(regWrite), .regRead(regRead), .regRData(regRData),
	.modSample(modSample), .modTake(modTake), .outWord(outWord), .outValid(outValid), .outReady(outReady));
`default_nettype wire

// file: tb/test_dfc_filter_chain.sv
// Self-checking bench for the decimating filter chain
`timescale 1ns/1ns
`default_nettype none
module test_dfc_filter_chain;
	import dfc_pkg::*;
	// ************************************************************
	// Signals and register rows
	// ************************************************************
	typedef struct {logic wr; logic [3:0] a; logic [31:0] d, m, e;} dfc_row_type;
	logic              clock = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, outReady = 1'b1;
	logic              modTake, outValid;
	logic [3:0]        regAddr = 4'h0;
	logic [31:0]       regWData = 32'h0, regRData, rd, gap;
	logic signed [3:0] level = 4'sh3, modSample;
	logic [15:0]       takes, t0;
	dfc_word_type      outWord, w;
	int                num_errors = 0, comparisons = 0, cycles = 0, cnt;
	// Write flag, address, data, read mask, expected value
	dfc_row_type       rows [12] = '{
		'{1'b0, 4'h0, 32'h0, 32'hFFFFFFFF, 32'h1A}, '{1'b0, 4'h4, 32'h0, 32'hFFFFFFFF, 32'h0},
		'{1'b0, 4'h8, 32'h0, 32'hFFFFFFFF, 32'h100}, '{1'b0, 4'h2, 32'h0, 32'hFFFFFFFF, 32'h0},
		'{1'b1, 4'h8, 32'h12345, 32'h0, 32'h0}, '{1'b0, 4'h8, 32'h0, 32'hFFFFFFFF, 32'h2345},
		'{1'b1, 4'hC, 32'hFFFFFFFF, 32'h0, 32'h0}, '{1'b1, 4'h0, 32'h3, 32'h0, 32'h0},
		'{1'b0, 4'hC, 32'h0, 32'h1, 32'h1}, '{1'b1, 4'h0, 32'h1A, 32'h0, 32'h0},
		'{1'b0, 4'hC, 32'h0, 32'h1, 32'h0}, '{1'b0, 4'h0, 32'h0, 32'hFFFFFFFF, 32'h1A}};
	always #20 clock = ~clock;
	dfc_filter_chain i_dfc_filter_chain (.clock(clock), .rst(rst), .regAddr(regAddr), .regWData(regWData),
		.regWrite(regWrite), .regRead(regRead), .regRData(regRData), .modSample(modSample), .modTake(modTake),
		.outWord(outWord), .outValid(outValid), .outReady(outReady));
	dfc_modulator_model i_dfc_modulator_model (.clock(clock), .rst(rst), .modTake(modTake), .level(level),
		.modSample(modSample), .takes(takes));
	// ************************************************************
	// Compare, bus and stream tasks
	// ************************************************************
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkFlag(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic regWr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock) {regAddr, regWData, regWrite} <= {a, d, 1'b1};
		@(posedge clock) regWrite <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic regRd(input logic [3:0] a);
		@(posedge clock) {regAddr, regRead} <= {a, 1'b1};
		@(posedge clock) regRead <= 1'b0;
		#1 rd = regRData;
	endtask
	// Reset, then load a configuration
	task automatic restart(input logic [31:0] cfg, input logic rdy);
		@(posedge clock) {rst, outReady} <= {1'b1, rdy};
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		regWr(DFC_REG_CONFIG, cfg);
	endtask
	// Next head word and the cycles waited for it
	task automatic getWord();
		gap = 32'h0;
		do begin
			@(posedge clock);
			#1 gap++;
		end while (!outValid && gap < 32'h1388);
		w = outWord;
		chkFlag(outValid, 1'b1);
	endtask
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			results();
		end
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1 chkFlag(outValid, 1'b0);
		chkVal(regRData, 32'h0);
		foreach (rows[i]) begin
			if (rows[i].wr) regWr(rows[i].a, rows[i].d);
			else begin
				regRd(rows[i].a);
				chkVal(rd & rows[i].m, rows[i].e);
			end
		end
		$display("register rows done");
		// Sinc path at three ratios: word spacing and unity dc gain
		for (int r = 0; r < 3; r++) begin
			restart({26'h0, 3'(r), 3'h0}, 1'b1);
			// Level 3 plus or minus one of dither; the sign flips after 16 words
			for (int k = 0; k < 24; k++) begin
				getWord();
				chkFlag(w.sincPath, 1'b1);
				if (k > 1) chkVal(gap, 32'h20 << r);
				if (k == 8) chkFlag(w.value == 32'h2000_0000 || w.value == 32'h4000_0000, 1'b1);
				if (k == 8) rd = w.value;
				if (k == 23) chkVal(w.value + rd, 32'h6000_0000);
			end
			$display("sinc rate %0d done", r);
		end
		// Low-power modulator rate halves the sinc word rate
		restart(32'h40, 1'b1);
		for (int k = 0; k < 4; k++) begin
			getWord();
			if (k > 1) chkVal(gap, 32'h40);
		end
		$display("low power done");
		// FIR linear, FIR code 01 minimum phase, FIR plus high-pass: decimation and clipping
		for (int p = 0; p < 3; p++) begin
			restart((p == 2) ? 32'h3 : (p == 1) ? 32'h5 : 32'h2, 1'b1);
			for (int k = 0; k < 4; k++) begin
				getWord();
				chkFlag(w.sincPath, 1'b0);
				if (k > 1) chkVal(gap, 32'h400);
				chkFlag(w.value <= DFC_CLIP_MAX && w.value >= DFC_CLIP_MIN, 1'b1);
				if (k == 3) chkVal(w.value, DFC_CLIP_MAX);
			end
			regRd(DFC_REG_STATUS);
			chkVal(rd & 32'h9, (p == 2) ? 32'h1 : 32'h0);
			$display("fir case %0d done", p);
		end
		// Full buffer stalls sampling, then drains whole
		restart(32'h0, 1'b0);
		repeat (700) @(posedge clock);
		#1 t0 = takes;
		regRd(DFC_REG_STATUS);
		chkVal(rd & 32'h1F4, 32'h100);
		repeat (64) @(posedge clock);
		#1 chkVal({16'h0, takes}, {16'h0, t0});
		@(posedge clock) outReady <= 1'b1;
		cnt = 0;
		// The first word pops on the edge after the one that raises ready
		for (int i = 0; i < 16; i++) begin
			getWord();
			if (gap == 32'h1) cnt++;
		end
		chkVal(32'(cnt), 32'hF);
		$display("buffer test done");
		results();
	end
endmodule
`default_nettype wire
